// ===== rtl/lcm_regs.sv
// Overview of operation
// - input pin level is read back live in the level register bits 4-0
// - output pin drives the written level bit until rewritten
// - alternate panel data function overrides pin direction and level
// - 8-bit scratch register stores and reads back, affecting nothing
// - rotation enable bit 7 selects portrait refresh, else landscape
// - rotation type bit 6 picks default or alternate method when rotated
// - landscape ignores clock select; pixel at base, memory per config bit
// - default rotation: codes 0-3 divide both clocks by 1,2,4,8
// - alternate rotation: pixel /2,/2,/4,/8 and memory /1,/1,/2,/4
// - base clock is the input clock, halved when config bit 4 set
// - rotated refresh advances line address by the stride byte count
// - horizontal active is field plus one times eight pixel clocks
// - horizontal blank is field plus four times eight pixel clocks
// - vertical active is ten-bit split field plus one lines
// - vertical blank is the six-bit field in lines, no offset
// - frame length is line times lines; dual panel doubles line times halved active plus blank
// - gray modes use only green table with two, four, sixteen or (8 bpp) eight entries
// - colour modes bank each table per depth; 8 bpp splits as 8,8,4
// - host table access addresses every entry regardless of banking
// - direction bit zero makes pin input, one makes it output
// - bank select fields choose display bank; no effect at 4 bpp
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module lcm_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire lcm_pkg::lcm_apb_req_t apb_req,
   output lcm_pkg::lcm_apb_rsp_t apb_rsp,
   input wire logic [4:0] gpio_in,
   output lcm_pkg::lcm_gpio_t gpio,
   input wire logic [3:0] panel_data_upper_bits,
   input wire logic [7:0] pix_value,
   input wire logic line_start,
   input wire logic frame_start,
   input wire logic [15:0] start_addr,
   input wire logic [7:0] landscape_line_bytes,
   output logic [15:0] refresh_addr,
   output logic pix_clk_en,
   output logic mem_clk_en,
   output logic rot_enable,
   output logic rot_alternate,
   output logic [11:0] rgb_out,
   output logic [10:0] h_active_period,
   output logic [10:0] h_blank_period,
   output logic [10:0] v_active_period,
   output logic [5:0] v_blank_period,
   output logic [23:0] frame_pclks
);
   import lcm_pkg::*;

   typedef struct packed {
      logic [4:0] dir;
      logic [4:0] lvl;
      logic [7:0] scratch;
      logic [7:0] rot;
      logic [7:0] stride;
      logic [5:0] lut_ptr;
      logic [5:0] bank;
      logic [7:0] clk_cfg;
      logic [4:0] disp;
      logic [6:0] h_act_f;
      logic [4:0] h_blk_f;
      logic [7:0] v_act_lo;
      logic [1:0] v_act_hi;
      logic [5:0] v_blk_f;
      logic [31:0] prdata;
      logic [15:0] raddr;
      logic [10:0] h_act;
      logic [10:0] h_blk;
      logic [10:0] v_act;
      logic [5:0] v_blk;
      logic [23:0] frame;
   } lcm_st_t;

   lcm_st_t q, d;
   logic [15:0] word;
   logic mapped, test_loc, bad, setup, wr_acc;
   logic [7:0] rd_byte;
   logic [3:0] lut_rdata;
   logic [4:0] lvl_view;
   logic [4:0] alt;
   logic [2:0] base_sh, sel3, pix_sh, mem_sh;
   logic [10:0] line_len, v_tot, v_dual;

   assign word = apb_req.paddr[ADDR_W-1:2];
   assign setup = apb_req.psel & ~apb_req.penable;

   always_comb
   begin
      mapped = 1'b1;
      unique case (word)
         IX_DISP, IX_CLK, IX_H_ACT, IX_V_ACT_LO, IX_V_ACT_HI, IX_H_BLK, IX_V_BLK,
         IX_LUT_PTR, IX_BANK, IX_LUT_DATA, IX_GPIO_DIR, IX_GPIO_LVL, IX_SCRATCH,
         IX_ROT, IX_STRIDE, IX_TEST0, IX_TEST1: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // test locations read as zero; writes to them are refused outright
   assign test_loc = (word == IX_TEST0) | (word == IX_TEST1);
   assign bad = ~mapped | (apb_req.paddr[1:0] != 2'b00) | (test_loc & apb_req.pwrite);
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & ~bad;

   // alternate function owns the upper panel data pins in thin-film mode
   assign alt = q.disp[CFG_TFT] ? GPIO_ALT_MASK : 5'h00;
   assign lvl_view = (q.dir & q.lvl) | (~q.dir & gpio_in);

   always_comb
   begin
      rd_byte = RST8;
      unique case (word)
         IX_DISP: rd_byte = {3'b000, q.disp};
         IX_CLK: rd_byte = q.clk_cfg;
         IX_H_ACT: rd_byte = {1'b0, q.h_act_f};
         IX_V_ACT_LO: rd_byte = q.v_act_lo;
         IX_V_ACT_HI: rd_byte = {6'h00, q.v_act_hi};
         IX_H_BLK: rd_byte = {3'b000, q.h_blk_f};
         IX_V_BLK: rd_byte = {2'b00, q.v_blk_f};
         IX_LUT_PTR: rd_byte = {2'b00, q.lut_ptr};
         IX_BANK: rd_byte = {2'b00, q.bank};
         IX_LUT_DATA: rd_byte = {4'h0, lut_rdata};
         IX_GPIO_DIR: rd_byte = {3'b000, q.dir};
         IX_GPIO_LVL: rd_byte = {3'b000, lvl_view};
         IX_SCRATCH: rd_byte = q.scratch;
         IX_ROT: rd_byte = q.rot;
         IX_STRIDE: rd_byte = q.stride;
         default: rd_byte = RST8;
      endcase
   end

   // clock ratios as power-of-two shifts of the input clock
   always_comb
   begin
      base_sh = {2'b00, q.clk_cfg[CLK_HALF]};
      sel3 = {1'b0, q.rot[1:0]};
      if (!q.rot[ROT_EN])
      begin
         pix_sh = base_sh;
         mem_sh = base_sh + {2'b00, q.clk_cfg[MCLK_HALF]};
      end
      else if (!q.rot[ROT_ALT])
      begin
         pix_sh = base_sh + sel3;
         mem_sh = base_sh + sel3;
      end
      else
      begin
         // memory must run at least twice the pixel rate here
         pix_sh = base_sh + ((sel3 == 3'd0) ? 3'd1 : sel3);
         mem_sh = pix_sh - 3'd1;
      end
   end

   assign line_len = q.h_act + q.h_blk;
   assign v_tot = q.v_act + {5'h00, q.v_blk};
   assign v_dual = {1'b0, q.v_act[10:1]} + {5'h00, q.v_blk};

   always_comb
   begin
      d = q;
      if (setup)
         d.prdata = bad ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      if (wr_acc)
      begin
         unique case (word)
            IX_DISP: d.disp = apb_req.pwdata[4:0];
            IX_CLK: d.clk_cfg = apb_req.pwdata[7:0];
            IX_H_ACT: d.h_act_f = apb_req.pwdata[6:0];
            IX_V_ACT_LO: d.v_act_lo = apb_req.pwdata[7:0];
            IX_V_ACT_HI: d.v_act_hi = apb_req.pwdata[1:0];
            IX_H_BLK: d.h_blk_f = apb_req.pwdata[4:0];
            IX_V_BLK: d.v_blk_f = apb_req.pwdata[5:0];
            IX_LUT_PTR: d.lut_ptr = apb_req.pwdata[5:0];
            IX_BANK: d.bank = apb_req.pwdata[5:0];
            IX_GPIO_DIR: d.dir = apb_req.pwdata[4:0];
            IX_GPIO_LVL: d.lvl = apb_req.pwdata[4:0];
            IX_SCRATCH: d.scratch = apb_req.pwdata[7:0];
            // reserved bits 5-2 are not stored and read as zero
            IX_ROT: d.rot = {apb_req.pwdata[7:6], 4'h0, apb_req.pwdata[1:0]};
            IX_STRIDE: d.stride = apb_req.pwdata[7:0];
            default: d.scratch = q.scratch;
         endcase
      end
      // derived periods follow the fields one edge later, frame length two edges later
      d.h_act = ({4'h0, q.h_act_f} + H_ACT_OFS) << H_UNIT_SH;
      d.h_blk = ({6'h00, q.h_blk_f} + H_BLK_OFS) << H_UNIT_SH;
      d.v_act = {1'b0, q.v_act_hi, q.v_act_lo} + V_ACT_OFS;
      d.v_blk = q.v_blk_f;
      if (q.disp[CFG_DUAL])
         d.frame = 24'(line_len * v_dual) << 1;
      else
         d.frame = {2'b00, 22'(line_len * v_tot)};
      if (frame_start)
         d.raddr = start_addr;
      else if (line_start)
         d.raddr = q.raddr + {8'h00, q.rot[ROT_EN] ? q.stride : landscape_line_bytes};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   lcm_clk_div #(
      .CNT_W(4),
      .SH_W(3)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .pix_sh(pix_sh),
      .mem_sh(mem_sh),
      .pix_en(pix_clk_en),
      .mem_en(mem_clk_en)
   );

   lcm_lut u_lut (
      .pclk(pclk),
      .presetn(presetn),
      .host_we(wr_acc && (word == IX_LUT_DATA)),
      .host_ptr(q.lut_ptr),
      .host_wdata(apb_req.pwdata[3:0]),
      .host_rdata(lut_rdata),
      .bpp(lcm_bpp_t'(q.disp[1:0])),
      .color(q.disp[CFG_COLOR]),
      .bank_sel(q.bank),
      .pix(pix_value),
      .rgb(rgb_out)
   );

   // zero wait states: read data is latched in the setup phase
   assign apb_rsp.prdata = q.prdata;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & bad;

   always_comb
   begin
      gpio.out = (alt & {1'b0, panel_data_upper_bits}) | (~alt & q.lvl);
      gpio.oe = alt | q.dir;
   end

   assign rot_enable = q.rot[ROT_EN];
   assign rot_alternate = q.rot[ROT_EN] & q.rot[ROT_ALT];
   assign refresh_addr = q.raddr;
   assign h_active_period = q.h_act;
   assign h_blank_period = q.h_blk;
   assign v_active_period = q.v_act;
   assign v_blank_period = q.v_blk;
   assign frame_pclks = q.frame;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic rot_def, rot_alt_m, land;
   assign rot_def = q.rot[ROT_EN] & ~q.rot[ROT_ALT] & ~q.clk_cfg[CLK_HALF];
   assign rot_alt_m = q.rot[ROT_EN] & q.rot[ROT_ALT] & ~q.clk_cfg[CLK_HALF];
   assign land = ~q.rot[ROT_EN];

   a_gpio_in_read: assert property (setup && !bad && word == IX_GPIO_LVL && q.dir == 5'h00
      |=> apb_rsp.prdata[4:0] == $past(gpio_in))
      else $error("input pin level not returned");
   a_gpio_out_drive: assert property (wr_acc && word == IX_GPIO_LVL && q.dir[4]
      |=> gpio.out[4] == $past(apb_req.pwdata[4]) && gpio.oe[4])
      else $error("written level not driven");
   a_gpio_alt_own: assert property (q.disp[CFG_TFT]
      |-> gpio.oe[3:0] == 4'hf && gpio.out[3:0] == panel_data_upper_bits)
      else $error("alternate function not driving pins");
   a_scratch_hold: assert property (wr_acc && word == IX_SCRATCH
      |=> ##1 q.scratch == $past(apb_req.pwdata[7:0], 2))
      else $error("scratch value lost");
   a_land_pix_full: assert property ((land && !q.clk_cfg[CLK_HALF])[*2] |-> pix_clk_en)
      else $error("landscape pixel strobe not at base rate");
   a_def_same_rate: assert property (rot_def [*2] |-> pix_clk_en == mem_clk_en)
      else $error("default rotation clocks differ");
   a_def_div_two: assert property ((rot_def && q.rot[1:0] == 2'b01)[*3] ##0 pix_clk_en
      |-> !$past(pix_clk_en))
      else $error("default rotation not divided by two");
   a_alt_mem_full: assert property ((rot_alt_m && q.rot[1] == 1'b0)[*3]
      |-> mem_clk_en && (pix_clk_en != $past(pix_clk_en)))
      else $error("alternate rotation ratio wrong");
   a_half_base: assert property ((land && q.clk_cfg[CLK_HALF])[*3] ##0 pix_clk_en
      |-> !$past(pix_clk_en))
      else $error("halved base clock not applied");
   a_stride_step: assert property (line_start && !frame_start && q.rot[ROT_EN]
      |=> q.raddr == $past(q.raddr) + {8'h00, $past(q.stride)})
      else $error("refresh address not advanced by stride");
   a_test_refuse: assert property (apb_req.psel && apb_req.penable && apb_req.pwrite && test_loc
      |-> apb_rsp.pslverr)
      else $error("test location write accepted");
   a_h_active: assert property ($stable(q.h_act_f)
      |=> q.h_act == ({4'h0, $past(q.h_act_f)} + 11'h001) * 11'd8)
      else $error("horizontal active period wrong");
   a_frame_len: assert property (!q.disp[CFG_DUAL] && $stable(q.h_act) && $stable(q.h_blk)
      && $stable(q.v_act) && $stable(q.v_blk) && $stable(q.disp)
      |-> q.frame == 24'((q.h_act + q.h_blk) * (q.v_act + q.v_blk)))
      else $error("frame length wrong");
   a_gray_green: assert property (!$past(q.disp[CFG_COLOR])
      |-> rgb_out[11:8] == rgb_out[7:4] && rgb_out[3:0] == rgb_out[7:4])
      else $error("gray mode not green only");

   c_rot_default: cover property (rot_def && q.rot[1:0] == 2'b11 && pix_clk_en);
   c_rot_alt: cover property (rot_alt_m && q.rot[1:0] == 2'b10 && mem_clk_en && !pix_clk_en);
   c_gpio_read: cover property (setup && word == IX_GPIO_LVL && q.dir != 5'h1f);
   c_dual_frame: cover property (q.disp[CFG_DUAL] && line_start);
endmodule
`default_nettype wire

// ===== rtl/lcm_pkg.sv
`default_nettype none
package lcm_pkg;
   localparam int ADDR_W = 18;
   localparam int GPIO_N = 5;
   localparam logic [4:0] GPIO_ALT_MASK = 5'h0f;
   localparam logic [7:0] RST8 = 8'h00;
   // register indices; byte address is four times the index
   localparam logic [15:0] IX_DISP = 16'hffe1;
   localparam logic [15:0] IX_CLK = 16'hffe2;
   localparam logic [15:0] IX_H_ACT = 16'hffe4;
   localparam logic [15:0] IX_V_ACT_LO = 16'hffe5;
   localparam logic [15:0] IX_V_ACT_HI = 16'hffe6;
   localparam logic [15:0] IX_H_BLK = 16'hffe8;
   localparam logic [15:0] IX_V_BLK = 16'hffea;
   localparam logic [15:0] IX_LUT_PTR = 16'hfff5;
   localparam logic [15:0] IX_BANK = 16'hfff6;
   localparam logic [15:0] IX_LUT_DATA = 16'hfff7;
   localparam logic [15:0] IX_GPIO_DIR = 16'hfff8;
   localparam logic [15:0] IX_GPIO_LVL = 16'hfff9;
   localparam logic [15:0] IX_SCRATCH = 16'hfffa;
   localparam logic [15:0] IX_ROT = 16'hfffb;
   localparam logic [15:0] IX_STRIDE = 16'hfffc;
   localparam logic [15:0] IX_TEST0 = 16'hfffe;
   localparam logic [15:0] IX_TEST1 = 16'hffff;
   // field positions
   localparam int ROT_EN = 7;
   localparam int ROT_ALT = 6;
   localparam int CLK_HALF = 4;
   localparam int MCLK_HALF = 5;
   localparam int CFG_COLOR = 2;
   localparam int CFG_DUAL = 3;
   localparam int CFG_TFT = 4;
   // timing encodings
   localparam int H_UNIT_SH = 3;
   localparam logic [10:0] H_ACT_OFS = 11'h001;
   localparam logic [10:0] H_BLK_OFS = 11'h004;
   localparam logic [10:0] V_ACT_OFS = 11'h001;
   typedef enum logic [1:0] {BPP1, BPP2, BPP4, BPP8} lcm_bpp_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } lcm_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lcm_apb_rsp_t;
   typedef struct packed {
      logic [GPIO_N-1:0] out;
      logic [GPIO_N-1:0] oe;
   } lcm_gpio_t;
endpackage
`default_nettype wire

// ===== rtl/lcm_clk_div.sv
`default_nettype none
module lcm_clk_div #(
   parameter int CNT_W = 4,
   parameter int SH_W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [SH_W-1:0] pix_sh,
   input wire logic [SH_W-1:0] mem_sh,
   output logic pix_en,
   output logic mem_en
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic pix;
      logic mem;
   } lcm_div_st_t;
   lcm_div_st_t q, d;

   function automatic logic [CNT_W-1:0] sh_mask(input logic [SH_W-1:0] s);
      sh_mask = CNT_W'((1 << s) - 1);
   endfunction

   // one shared counter keeps both strobes phase aligned; a new ratio
   // only changes which counts fire, so no runt strobe is possible
   always_comb
   begin
      d = q;
      d.cnt = q.cnt + 1'b1;
      d.pix = (d.cnt & sh_mask(pix_sh)) == sh_mask(pix_sh);
      d.mem = (d.cnt & sh_mask(mem_sh)) == sh_mask(mem_sh);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   assign pix_en = q.pix;
   assign mem_en = q.mem;
endmodule
`default_nettype wire

// ===== rtl/lcm_lut.sv
`default_nettype none
module lcm_lut (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic host_we,
   input wire logic [5:0] host_ptr,
   input wire logic [3:0] host_wdata,
   output logic [3:0] host_rdata,
   input wire lcm_pkg::lcm_bpp_t bpp,
   input wire logic color,
   input wire logic [5:0] bank_sel,
   input wire logic [7:0] pix,
   output logic [11:0] rgb
);
   import lcm_pkg::*;
   logic [3:0] mem [48];
   logic [5:0] host_a;
   logic [3:0] r_ix, g_ix, b_ix;

   function automatic logic [3:0] lut_index(input lcm_bpp_t m, input logic [1:0] bank,
                                            input logic [3:0] px, input logic eight);
      unique case (m)
         BPP1: lut_index = {1'b0, bank, px[0]};
         BPP2: lut_index = {bank, px[1:0]};
         BPP4: lut_index = px;
         BPP8: lut_index = eight ? {bank[0], px[2:0]} : {bank, px[1:0]};
      endcase
   endfunction

   // host side sees every entry, whatever banking the display uses
   assign host_a = {(host_ptr[5:4] == 2'b11) ? 2'd2 : ((host_ptr[5:4] == 2'b10) ? 2'd1 : 2'd0),
                    host_ptr[3:0]};
   assign r_ix = lut_index(bpp, bank_sel[5:4], (bpp == BPP8) ? {1'b0, pix[7:5]} : pix[3:0], 1'b1);
   assign g_ix = lut_index(bpp, bank_sel[3:2], (bpp == BPP8) ? {1'b0, pix[4:2]} : pix[3:0], 1'b1);
   assign b_ix = lut_index(bpp, bank_sel[1:0], (bpp == BPP8) ? {2'b00, pix[1:0]} : pix[3:0], 1'b0);

   always_ff @(posedge pclk or negedge presetn)
   begin
      // cleared so display output is known before software loads it
      if (!presetn)
      begin
         for (int i = 0; i < 48; i++)
            mem[i] <= 4'h0;
      end
      else if (host_we)
         mem[host_a] <= host_wdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_rdata <= '0;
         rgb <= '0;
      end
      else
      begin
         host_rdata <= mem[host_a];
         // gray shades come from the green table alone
         if (color)
            rgb <= {mem[{2'd0, r_ix}], mem[{2'd1, g_ix}], mem[{2'd2, b_ix}]};
         else
            rgb <= {3{mem[{2'd1, g_ix}]}};
      end
   end
endmodule
`default_nettype wire

// ===== verification/lcm_apb_host.sv
`default_nettype none
module lcm_apb_host (
   input wire logic pclk,
   input wire logic presetn,
   output var lcm_pkg::lcm_apb_req_t apb_req,
   input wire lcm_pkg::lcm_apb_rsp_t apb_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcm_pkg::*;
   initial apb_req = '0;
   // one transfer; request held until pready is seen high, for at most 16 cycles
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [1:0] lo, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er, output logic to);
      int n;
      // test locations are never written, a read goes out instead
      if (wr && (idx == IX_TEST0 || idx == IX_TEST1)) wr = 1'b0;
      if (idx == IX_ROT) wd[2] = 1'b0;
      rd = '0;
      er = 1'b0;
      to = 1'b1;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, lo}, pwdata: wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      for (n = 0; n < 16 && to; n++)
      begin
         @(posedge pclk);
         if (apb_rsp.pready === 1'b1)
         begin
            rd = apb_rsp.prdata;
            er = apb_rsp.pslverr;
            to = 1'b0;
         end
      end
      apb_req <= '0;
   endtask
endmodule
`default_nettype wire

// ===== verification/test_lcd_ctrl_misc_config_regs.sv
`default_nettype none
module test_lcd_ctrl_misc_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import lcm_pkg::*;
   typedef struct packed {logic [15:0] idx; logic [31:0] wd; logic [7:0] rexp; logic err;} lcm_row_t;
   typedef struct packed {logic [7:0] clkv; logic [7:0] rotv; logic [4:0] pp; logic [4:0] mp;} lcm_clk_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   lcm_apb_req_t apb_req;
   lcm_apb_rsp_t apb_rsp;
   lcm_gpio_t gpio;
   logic [4:0] gpio_in = '0;
   logic [3:0] panel_data_upper_bits = '0;
   logic [7:0] pix_value = '0;
   logic line_start = 1'b0;
   logic frame_start = 1'b0;
   logic [15:0] start_addr = '0;
   logic [7:0] landscape_line_bytes = '0;
   logic [15:0] refresh_addr;
   logic pix_clk_en, mem_clk_en, rot_enable, rot_alternate;
   logic [11:0] rgb_out;
   logic [10:0] h_active_period, h_blank_period, v_active_period;
   logic [5:0] v_blank_period;
   logic [23:0] frame_pclks;
   int errors = 0;
   int check_count = 0;
   lcm_row_t rows [6] = '{
      '{IX_SCRATCH, 32'hffffffa5, 8'ha5, 1'b0},
      '{IX_SCRATCH, 32'h0000005a, 8'h5a, 1'b0},
      '{IX_STRIDE, 32'h000000ff, 8'hff, 1'b0},
      '{IX_ROT, 32'h000000c7, 8'hc3, 1'b0},
      '{IX_ROT, 32'h0000003c, 8'h00, 1'b0},
      '{16'hfff0, 32'h00000011, 8'h00, 1'b1}};
   // pix and memory strobe periods per setting
   lcm_clk_row_t crows [11] = '{
      '{8'h00, 8'h03, 5'd1, 5'd1}, '{8'h10, 8'h43, 5'd2, 5'd2}, '{8'h20, 8'h00, 5'd1, 5'd2},
      '{8'h00, 8'h80, 5'd1, 5'd1}, '{8'h00, 8'h81, 5'd2, 5'd2}, '{8'h00, 8'h82, 5'd4, 5'd4},
      '{8'h10, 8'h83, 5'd16, 5'd16}, '{8'h00, 8'hc0, 5'd2, 5'd1}, '{8'h00, 8'hc1, 5'd2, 5'd1},
      '{8'h00, 8'hc2, 5'd4, 5'd2}, '{8'h00, 8'hc3, 5'd8, 5'd4}};
   lcm_regs dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .gpio_in(gpio_in),
      .gpio(gpio), .panel_data_upper_bits(panel_data_upper_bits), .pix_value(pix_value),
      .line_start(line_start), .frame_start(frame_start), .start_addr(start_addr),
      .landscape_line_bytes(landscape_line_bytes), .refresh_addr(refresh_addr), .pix_clk_en(pix_clk_en),
      .mem_clk_en(mem_clk_en), .rot_enable(rot_enable), .rot_alternate(rot_alternate), .rgb_out(rgb_out),
      .h_active_period(h_active_period), .h_blank_period(h_blank_period), .v_active_period(v_active_period),
      .v_blank_period(v_blank_period), .frame_pclks(frame_pclks));
   lcm_apb_host host_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp));
   initial
   begin
      forever #2 pclk = ~pclk;
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask
   task automatic acc(input logic wr, input logic [15:0] idx, input logic [1:0] lo, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      logic to;
      host_u.xfer(wr, idx, lo, wd, rd, er, to);
      if (to !== 1'b0)
      begin
         $display("[ERR] pready expected 1 seen timeout");
         errors++;
         give_verdict();
      end
   endtask
   task automatic wreg(input logic [15:0] idx, input logic [7:0] v);
      logic [31:0] rd;
      logic er;
      acc(1'b1, idx, 2'b00, {24'h0, v}, rd, er);
   endtask
   task automatic rreg(input string nm, input logic [15:0] idx, input logic [7:0] exp);
      logic [31:0] rd;
      logic er;
      acc(1'b0, idx, 2'b00, 32'h0, rd, er);
      chk(nm, {24'h0, exp}, rd);
   endtask
   task automatic strobe_line(input logic fr);
      @(posedge pclk);
      frame_start <= fr;
      line_start <= ~fr;
      @(posedge pclk);
      frame_start <= 1'b0;
      line_start <= 1'b0;
      @(negedge pclk);
   endtask
   function automatic logic [3:0] lv(input int t, input int e);
      return 4'(e + 4 * t);
   endfunction
   initial
   begin
      logic [31:0] rd;
      logic er;
      int np, nm;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(negedge pclk);
      chk("h_active reset", 32'd8, {21'h0, h_active_period});
      chk("h_blank reset", 32'd32, {21'h0, h_blank_period});
      chk("oe reset", 32'h0, {27'h0, gpio.oe});
      rreg("scratch reset", IX_SCRATCH, 8'h00);
      foreach (rows[i])
      begin
         acc(1'b1, rows[i].idx, 2'b00, rows[i].wd, rd, er);
         chk("write err", {31'h0, rows[i].err}, {31'h0, er});
         acc(1'b0, rows[i].idx, 2'b00, 32'h0, rd, er);
         chk("read data", {24'h0, rows[i].rexp}, rd);
         chk("read err", {31'h0, rows[i].err}, {31'h0, er});
      end
      acc(1'b0, IX_SCRATCH, 2'b01, 32'h0, rd, er);
      chk("misaligned err", 32'h1, {31'h0, er});
      foreach (crows[i])
      begin
         wreg(IX_CLK, crows[i].clkv);
         wreg(IX_ROT, crows[i].rotv);
         @(negedge pclk);
         chk("rot_enable", {31'h0, crows[i].rotv[7]}, {31'h0, rot_enable});
         chk("rot_alternate", {31'h0, crows[i].rotv[7] & crows[i].rotv[6]}, {31'h0, rot_alternate});
         repeat (20) @(posedge pclk);
         np = 0;
         nm = 0;
         repeat (64)
         begin
            @(negedge pclk);
            if (pix_clk_en === 1'b1) np++;
            if (mem_clk_en === 1'b1) nm++;
         end
         chk("pix strobes", 32'(64 / crows[i].pp), 32'(np));
         chk("mem strobes", 32'(64 / crows[i].mp), 32'(nm));
      end
      wreg(IX_CLK, 8'h00);
      wreg(IX_H_ACT, 8'h07);
      wreg(IX_V_ACT_LO, 8'h2f);
      wreg(IX_V_ACT_HI, 8'h01);
      wreg(IX_H_BLK, 8'h05);
      wreg(IX_V_BLK, 8'h0a);
      wreg(IX_DISP, 8'h00);
      repeat (3) @(negedge pclk);
      chk("h_active", 32'd64, {21'h0, h_active_period});
      chk("h_blank", 32'd72, {21'h0, h_blank_period});
      chk("v_active", 32'd304, {21'h0, v_active_period});
      chk("v_blank", 32'd10, {26'h0, v_blank_period});
      chk("frame single", 32'd42704, {8'h0, frame_pclks});
      wreg(IX_DISP, 8'h08);
      repeat (3) @(negedge pclk);
      chk("frame dual", 32'd44064, {8'h0, frame_pclks});
      @(posedge pclk);
      gpio_in <= 5'h15;
      wreg(IX_GPIO_DIR, 8'h00);
      rreg("pin level in", IX_GPIO_LVL, 8'h15);
      gpio_in <= 5'h0b;
      rreg("pin level live", IX_GPIO_LVL, 8'h0b);
      wreg(IX_GPIO_DIR, 8'h1f);
      wreg(IX_GPIO_LVL, 8'h0a);
      @(negedge pclk);
      chk("pin out", 32'h0a, {27'h0, gpio.out});
      chk("pin oe", 32'h1f, {27'h0, gpio.oe});
      @(posedge pclk);
      panel_data_upper_bits <= 4'h5;
      wreg(IX_GPIO_DIR, 8'h10);
      wreg(IX_GPIO_LVL, 8'h1a);
      wreg(IX_DISP, 8'h10);
      @(negedge pclk);
      chk("alt pin out", 32'h15, {27'h0, gpio.out});
      chk("alt pin oe", 32'h1f, {27'h0, gpio.oe});
      wreg(IX_ROT, 8'h80);
      wreg(IX_STRIDE, 8'h80);
      start_addr <= 16'h1000;
      landscape_line_bytes <= 8'h28;
      strobe_line(1'b1);
      chk("refresh frame", 32'h1000, {16'h0, refresh_addr});
      strobe_line(1'b0);
      chk("refresh rotated", 32'h1080, {16'h0, refresh_addr});
      wreg(IX_ROT, 8'h00);
      strobe_line(1'b0);
      chk("refresh landscape", 32'h10a8, {16'h0, refresh_addr});
      for (int t = 1; t < 4; t++)
         for (int e = 0; e < 16; e++)
         begin
            wreg(IX_LUT_PTR, 8'((t << 4) | e));
            wreg(IX_LUT_DATA, {4'h0, lv(t, e)});
         end
      wreg(IX_LUT_PTR, 8'h15);
      rreg("red entry", IX_LUT_DATA, {4'h0, lv(1, 5)});
      wreg(IX_LUT_PTR, 8'h3c);
      rreg("blue entry", IX_LUT_DATA, {4'h0, lv(3, 12)});
      pix_value <= 8'h03;
      wreg(IX_DISP, 8'h06);
      repeat (4) @(negedge pclk);
      chk("rgb 4bpp colour", {20'h0, lv(1, 3), lv(2, 3), lv(3, 3)}, {20'h0, rgb_out});
      wreg(IX_BANK, 8'h3f);
      repeat (4) @(negedge pclk);
      chk("rgb bank ignored", {20'h0, lv(1, 3), lv(2, 3), lv(3, 3)}, {20'h0, rgb_out});
      wreg(IX_DISP, 8'h02);
      repeat (4) @(negedge pclk);
      chk("rgb 4bpp gray", {20'h0, lv(2, 3), lv(2, 3), lv(2, 3)}, {20'h0, rgb_out});
      @(posedge pclk);
      pix_value <= 8'h01;
      wreg(IX_BANK, 8'h1b);
      wreg(IX_DISP, 8'h05);
      repeat (4) @(negedge pclk);
      chk("rgb 2bpp banked", {20'h0, lv(1, 5), lv(2, 9), lv(3, 13)}, {20'h0, rgb_out});
      // second reset in mid-run must clear stored state
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rreg("scratch after reset", IX_SCRATCH, 8'h00);
      rreg("rot after reset", IX_ROT, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
